// [core/pdac_pkg.sv]
/*
  pdac_pkg: register map, field positions, reset values and carrier types
  for the partial display area control block.
  assumes: 32-bit apb data, one aligned word per register.
*/
package pdac_pkg;

  localparam logic [7:0] PDAC_CTRL_OFF = 8'he4;
  localparam logic [7:0] PDAC_PANEL_OFF = 8'hf0;

  localparam int PDAC_CYC_LSB = 8;
  localparam int PDAC_CYC_MSB = 13;
  localparam int PDAC_EN_BIT = 4;
  localparam int PDAC_TYPE_BIT = 3;
  localparam int PDAC_AREA_LSB = 0;
  localparam int PDAC_AREA_N = 3;

  localparam logic [31:0] PDAC_CTRL_RST = 32'h0000_0000;
  localparam logic [1:0] PDAC_PANEL_RST = 2'h0;
  localparam logic [1:0] PDAC_PANEL_TYPE3 = 2'h2;

  typedef enum logic [1:0] {
    PDAC_IDLE = 2'b00,
    PDAC_ACC = 2'b01
  } pdac_state_t;

  // settings as seen by the panel timing generator
  typedef struct packed {
    logic active;
    logic block_mode;
    logic [2:0] area_en;
    logic [5:0] refresh;
  } pdac_cfg_t;

endpackage : pdac_pkg

// [core/pdac_gate.sv]
/*
  pdac_gate: masks the stored settings so that they reach the timing
  generator only while the third tft panel interface type is selected.
  assumes: one clock, asynchronous active-low reset.
*/
`timescale 1ns/100ps
module pdac_gate
  import pdac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic type3_sel,
  input wire logic [31:0] ctrl,
  output pdac_cfg_t cfg
);

  typedef struct packed {
    pdac_cfg_t cfg;
  } pdac_gate_st_t;

  pdac_gate_st_t st;
  pdac_gate_st_t next_st;

  always_comb begin
    next_st = st;
    if (type3_sel) begin
      next_st.cfg.active = ctrl[PDAC_EN_BIT];
      next_st.cfg.block_mode = ctrl[PDAC_TYPE_BIT];
      next_st.cfg.area_en = ctrl[PDAC_AREA_LSB +: PDAC_AREA_N];
      next_st.cfg.refresh = ctrl[PDAC_CYC_MSB:PDAC_CYC_LSB];
    end else begin
      next_st.cfg = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign cfg = st.cfg;

  ignore_other_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !$past(type3_sel) |-> cfg == '0)
    else $error("partial settings leak to another panel type");

  enable_follow_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    $past(type3_sel) |-> cfg.active == $past(ctrl[PDAC_EN_BIT]))
    else $error("partial enable does not follow control bit");

endmodule : pdac_gate

// [core/pdac_top.sv]
/*
  pdac_top: apb slave holding the partial display area control register
  and a panel type register, driving gated settings to the timing generator.
  assumes: apb master per amba apb3, single clock pclk at 40 MHz.
*/
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////
module pdac_top
  import pdac_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output pdac_cfg_t cfg
);

  ////////////////////////////////////////////////////////////////////////
  // register writable bits: 13..8 and 4..0; the rest read zero
  localparam logic [31:0] CTRL_MASK = 32'h0000_3f1f;

  typedef struct packed {
    pdac_state_t state;
    logic [31:0] ctrl;
    logic [1:0] panel;
    logic [31:0] rdata;
    logic ready;
    logic err;
  } pdac_st_t;

  pdac_st_t st;
  pdac_st_t next_st;

  // one wait state: the answer comes in the second access cycle
  always_comb begin
    next_st = st;
    next_st.ready = 1'b0;
    next_st.err = 1'b0;
    case (st.state)
      PDAC_IDLE: begin
        if (psel && penable && !st.ready) begin
          next_st.state = PDAC_ACC;
          next_st.ready = 1'b1;
          if (paddr == PDAC_CTRL_OFF) begin
            if (pwrite) begin
              next_st.ctrl = pwdata & CTRL_MASK;
            end else begin
              next_st.rdata = st.ctrl;
            end
          end else if (paddr == PDAC_PANEL_OFF) begin
            if (pwrite) begin
              next_st.panel = pwdata[1:0];
            end else begin
              next_st.rdata = {30'h0, st.panel};
            end
          end else begin
            next_st.err = 1'b1;
            next_st.rdata = 32'h0;
          end
        end
      end
      PDAC_ACC: begin
        next_st.state = PDAC_IDLE;
      end
      default: begin
        next_st.state = PDAC_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '{PDAC_IDLE, PDAC_CTRL_RST, PDAC_PANEL_RST, 32'h0, 1'b0, 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign prdata = st.rdata;
  assign pready = st.ready;
  assign pslverr = st.err;

  pdac_gate u_gate (
    .pclk(pclk),
    .presetn(presetn),
    .type3_sel(st.panel == PDAC_PANEL_TYPE3),
    .ctrl(st.ctrl),
    .cfg(cfg)
  );

  ////////////////////////////////////////////////////////////////////////
  // checks look one edge after the access is taken: the answer and the
  // stored value both come from registers, never from the bus directly
  refresh_store_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && !pready && paddr == PDAC_CTRL_OFF
    |=> st.ctrl[PDAC_CYC_MSB:PDAC_CYC_LSB]
    == $past(pwdata[PDAC_CYC_MSB:PDAC_CYC_LSB]))
    else $error("refresh cycle not stored");

  ctrl_mask_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && !pready && paddr == PDAC_CTRL_OFF
    |=> st.ctrl == ($past(pwdata) & CTRL_MASK))
    else $error("control write not stored through mask");

  ctrl_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(psel && penable && pwrite && !pready && paddr == PDAC_CTRL_OFF)
    |=> $stable(st.ctrl))
    else $error("control changed without a write");

  refresh_out_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.panel == PDAC_PANEL_TYPE3
    |=> cfg.refresh == $past(st.ctrl[PDAC_CYC_MSB:PDAC_CYC_LSB]))
    else $error("refresh cycle not passed on");

  other_panel_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.panel != PDAC_PANEL_TYPE3 |=> cfg == '0)
    else $error("settings act on another panel type");

  master_on_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.panel == PDAC_PANEL_TYPE3
    |=> cfg.active == $past(st.ctrl[PDAC_EN_BIT]))
    else $error("partial mode enable mismatch");

  layout_sel_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.panel == PDAC_PANEL_TYPE3 && $stable(st.panel)
    |=> cfg.block_mode == $past(st.ctrl[PDAC_TYPE_BIT]))
    else $error("layout select mismatch");

  stripe_sel_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.panel == PDAC_PANEL_TYPE3 && !st.ctrl[PDAC_TYPE_BIT]
    |=> !cfg.block_mode)
    else $error("stripe layout not selected");

  block_sel_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.panel == PDAC_PANEL_TYPE3 && st.ctrl[PDAC_TYPE_BIT]
    |=> cfg.block_mode)
    else $error("block layout not selected");

  area_en_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    st.panel == PDAC_PANEL_TYPE3 && $stable(st.panel)
    |=> cfg.area_en == $past(st.ctrl[PDAC_AREA_LSB +: PDAC_AREA_N]))
    else $error("area enables mismatch");

  // one check per area, so that two swapped enables show up by index
  for (genvar k = 0; k < PDAC_AREA_N; k++) begin : g_area
    area_bit_a: assert property (
      @(posedge pclk) disable iff (!presetn)
      st.panel == PDAC_PANEL_TYPE3
      |=> cfg.area_en[k] == $past(st.ctrl[PDAC_AREA_LSB + k]))
      else $error("single area enable mismatch");
  end

  reset_zero_a: assert property (
    @(posedge pclk)
    $rose(presetn)
    |-> st.ctrl == PDAC_CTRL_RST && st.panel == PDAC_PANEL_RST && cfg == '0)
    else $error("control not zero after reset");

  ready_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("pready longer than one cycle");

  answer_next_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");

  no_request_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(psel && penable) |=> !pready)
    else $error("pready without an access");

  read_back_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && !pready && paddr == PDAC_CTRL_OFF
    |=> prdata == $past(st.ctrl) && pready)
    else $error("read data not register value");

  rdata_keep_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && !pready
    && (paddr == PDAC_CTRL_OFF || paddr == PDAC_PANEL_OFF)
    |=> $stable(prdata))
    else $error("read data changed by a write");

  panel_store_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && pwrite && !pready && paddr == PDAC_PANEL_OFF
    |=> st.panel == $past(pwdata[1:0]))
    else $error("panel type not stored");

  panel_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && !pready && paddr == PDAC_PANEL_OFF
    |=> prdata == {30'h0, $past(st.panel)} && pready)
    else $error("panel type read mismatch");

  panel_hold_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    !(psel && penable && pwrite && !pready && paddr == PDAC_PANEL_OFF)
    |=> $stable(st.panel))
    else $error("panel type changed without a write");

  unmapped_err_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && paddr != PDAC_CTRL_OFF
    && paddr != PDAC_PANEL_OFF |=> pslverr)
    else $error("unmapped access without error");

  unmapped_zero_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready && paddr != PDAC_CTRL_OFF
    && paddr != PDAC_PANEL_OFF |=> prdata == 32'h0)
    else $error("unmapped access returns data");

  mapped_ok_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready
    && (paddr == PDAC_CTRL_OFF || paddr == PDAC_PANEL_OFF)
    |=> !pslverr)
    else $error("error on a mapped access");

  err_with_ready_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    pslverr |-> pready)
    else $error("pslverr outside the answer cycle");

  cov_write_c: cover property (@(posedge pclk)
    pready && !pslverr && $past(pwrite));
  cov_block_c: cover property (@(posedge pclk) cfg.active && cfg.block_mode);
  cov_stripe_c: cover property (@(posedge pclk)
    cfg.active && !cfg.block_mode && cfg.area_en == 3'h7);
  cov_err_c: cover property (@(posedge pclk) pslverr);
  cov_ignored_c: cover property (@(posedge pclk)
    st.panel != PDAC_PANEL_TYPE3 && st.ctrl[PDAC_EN_BIT]);

endmodule : pdac_top

// [test/pdac_panel.sv]
/*
  pdac_panel: panel side view of the gated partial display settings.
  assumes: cfg comes from pdac_top on the same pclk.
*/
`timescale 1ns/100ps
module pdac_panel
  import pdac_pkg::*;
(
  input wire logic pclk,
  input wire pdac_cfg_t cfg,
  output pdac_cfg_t seen
);
  // panel only latches settings on its clock, never mid-transfer values
  always_ff @(posedge pclk) begin
    seen <= cfg;
  end
endmodule : pdac_panel

// [test/partial_display_area_control_tb.sv]
/*
  partial_display_area_control_tb: apb tests of pdac_top against a model.
  assumes: pdac_pkg, pdac_top and pdac_panel compiled first.
*/
`timescale 1ns/100ps
module partial_display_area_control_tb
  import pdac_pkg::*;
;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r, seed = 32'h4f261185, mc = 32'h0;
  logic pready, pslverr, e;
  logic [1:0] mt = 2'h0;
  pdac_cfg_t cfg, seen;
  int err_total = 0, n_checks = 0;
  logic [31:0] exp_q [$];
  always #12.5 pclk = ~pclk;
  pdac_top pdac_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .cfg(cfg));
  pdac_panel pdac_panel_inst (.pclk(pclk), .cfg(cfg), .seen(seen));
  ////////////////////////////////////////////////////////////////////////
  function logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs
  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask : chk
  task finish_test;
    $display("checks=%0d mismatches=%0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    // no cycle limit here: only the watchdog may end a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    chk({31'h0, e}, {31'h0, a != PDAC_CTRL_OFF && a != PDAC_PANEL_OFF});
  endtask : apb
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(1, a, d);
    if (a == PDAC_CTRL_OFF) mc = d & 32'h3f1f;
    if (a == PDAC_PANEL_OFF) mt = d[1:0];
  endtask : wr
  task rd(input logic [7:0] a);
    exp_q.push_back(a == PDAC_CTRL_OFF ? mc :
      a == PDAC_PANEL_OFF ? {30'h0, mt} : 32'h0);
    apb(0, a, xs());
    chk(r, exp_q.pop_front());
  endtask : rd
  task cfgchk;
    repeat (4) @(posedge pclk);
    chk({21'h0, seen}, mt != PDAC_PANEL_TYPE3 ? 32'h0 :
      {21'h0, mc[4], mc[3], mc[2:0], mc[13:8]});
  endtask : cfgchk
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #1000000;
    err_total++;
    finish_test();
  end
  initial begin
    logic [31:0] tbl [6];
    tbl = '{32'h3f1f, 32'h1, 32'h2, 32'h4, 32'h8, 32'h10};
    repeat (16) @(posedge pclk);
    presetn <= 1;
    rd(PDAC_CTRL_OFF);
    cfgchk();
    $display("test reset done");
    wr(PDAC_PANEL_OFF, 32'h2);
    for (int i = 0; i < 30; i++) begin
      wr(PDAC_CTRL_OFF, i < 6 ? tbl[i] : xs());
      rd(PDAC_CTRL_OFF);
      cfgchk();
    end
    $display("test fields done");
    // every field set, so that a leak to another panel type is visible
    wr(PDAC_CTRL_OFF, 32'h3f1f);
    for (int t = 0; t < 5; t++) begin
      wr(PDAC_PANEL_OFF, t);
      cfgchk();
    end
    $display("test panel type done");
    wr(PDAC_PANEL_OFF, 32'h2);
    cfgchk();
    @(posedge pclk);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    presetn <= 1;
    mc = 32'h0;
    mt = 2'h0;
    rd(PDAC_CTRL_OFF);
    rd(PDAC_PANEL_OFF);
    cfgchk();
    $display("test reset again done");
    wr(8'h40, xs());
    rd(8'h40);
    rd(PDAC_CTRL_OFF);
    $display("test unmapped done");
    finish_test();
  end
endmodule : partial_display_area_control_tb
